/* core/hqc_band_norm_coder.v */
/*
 * Per-frame band norm quantiser and envelope coder. Takes squared-sum
 * energy per band from a coefficient stream, quantises band norms in
 * the log domain, limits the differentials, costs four coding methods,
 * writes the cheapest one as fields into an output FIFO and then lists
 * the reconstructed indices. Assumes the transform stage marks the last
 * coefficient of each band and sends all bands of a frame in order.
 */
`timescale 1ns/100ps
`include "hqc_defs.vh"
module hqc_band_norm_coder #(
   parameter COEF_W = 16,
   parameter COEF_FRAC = 3,
   parameter LEN_W = 7,
   parameter FIFO_DEPTH = 32,
   parameter [6:0] CTX_OFS = `HQC_DEF_CTX_OFS,
   parameter [127:0] RSZ_LEN = `HQC_DEF_LEN,
   parameter [255:0] RSZ_CODE = `HQC_DEF_CODE,
   parameter [383:0] CTX_LEN = {3{`HQC_DEF_LEN}},
   parameter [767:0] CTX_CODE = {3{`HQC_DEF_CODE}}
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [1:0] band_sel_i,
   input wire coef_valid_i,
   input wire [COEF_W-1:0] coef_i,
   input wire coef_band_end_i,
   output wire coef_ready_o,
   output wire field_valid_o,
   input wire field_ready_i,
   output wire [7:0] field_data_o,
   output wire [3:0] field_len_o,
   output reg recon_valid_o,
   output reg [5:0] recon_band_o,
   output reg [5:0] recon_idx_o,
   output reg frame_done_o
);
   localparam SUM_W = 2*COEF_W + LEN_W;
   localparam [8:0] IDX_TOP = `HQC_IDX_BIAS + 2*COEF_FRAC;
   localparam [8:0] ST_ACC = 9'h001;
   localparam [8:0] ST_DIV = 9'h002;
   localparam [8:0] ST_P1 = 9'h004;
   localparam [8:0] ST_P2 = 9'h008;
   localparam [8:0] ST_MODE = 9'h010;
   localparam [8:0] ST_FIRST = 9'h020;
   localparam [8:0] ST_SYM = 9'h040;
   localparam [8:0] ST_RECON = 9'h080;
   localparam [8:0] ST_DONE = 9'h100;

   reg [8:0] state, raw_idx;
   reg [SUM_W-1:0] sum_sq, quo, norm_sh;
   reg [LEN_W-1:0] len_cnt;
   reg [LEN_W:0] rem;
   reg [5:0] div_cnt, band, n_bands, cur, next_idx, msb_pos;
   reg [5:0] norm [0:`HQC_MAX_BANDS-1];
   reg [4:0] prev_sym;
   reg [11:0] cost_ctx, cost_rsz, cost_nrm, cost_best, fifo_word;
   reg [1:0] method, next_method, ctx_cls;
   reg rnd_up, fifo_push;
   reg [6:0] ctx_val;
   integer k;

   wire [2*COEF_W-1:0] sq;
   wire coef_take;
   wire [LEN_W:0] rem_sh;
   wire rem_ge;
   wire [5:0] cur_up;
   wire [4:0] cur_sym;
   wire [6:0] up_diff;
   wire [3:0] len_ctx;
   wire [3:0] len_rsz;
   wire [3:0] len_nrm;
   wire [7:0] code;
   wire [3:0] code_len;
   wire [11:0] cost_pack;
   wire fifo_ready;

   // position of the leading one, used to take log2 of the mean square
   function [5:0] hqc_msb;
      input [SUM_W-1:0] v;
      integer i;
      begin
         hqc_msb = 6'h00;
         for (i = 0; i < SUM_W; i = i + 1) begin
            if (v[i]) begin
               hqc_msb = i[5:0];
            end
         end
      end
   endfunction

   // upper minus lower index, capped at +16 and offset into 0..31
   function [4:0] hqc_sym;
      input [5:0] hi;
      input [5:0] lo;
      reg [6:0] d;
      begin
         d = {1'b0, hi} - {1'b0, lo} + `HQC_SYM_OFS;
         if (!d[6] && d > `HQC_DIFF_POS + `HQC_SYM_OFS) begin
            hqc_sym = 5'h1F;
         end else begin
            hqc_sym = d[4:0];
         end
      end
   endfunction

   // squares are never negative, so the sum stays unsigned
   assign sq = $signed(coef_i) * $signed(coef_i);
   assign coef_ready_o = (state == ST_ACC);
   assign coef_take = coef_valid_i & coef_ready_o;
   assign rem_sh = {rem[LEN_W-1:0], quo[SUM_W-1]};
   assign rem_ge = (rem_sh >= {1'b0, len_cnt});
   assign cur_up = cur + 6'h01;
   assign up_diff = {1'b0, norm[cur_up]} - {1'b0, norm[cur]};
   assign cur_sym = hqc_sym(norm[cur_up], norm[cur]);
   assign cost_pack = {6'h00, n_bands - 6'h01} * 12'h005;

   // log quantiser: round log2 of mean square against sqrt(2)
   always @* begin
      msb_pos = hqc_msb(quo);
      norm_sh = quo << (SUM_W - 1 - msb_pos);
      rnd_up = (norm_sh[SUM_W-1 -: 16] >= `HQC_SQRT2_Q16);
      raw_idx = IDX_TOP - {3'h0, msb_pos} - {8'h00, rnd_up};
      if (quo == {SUM_W{1'b0}} || raw_idx[8]) begin
         next_idx = (band == 6'h00) ? `HQC_BAND0_MAX : `HQC_LVL_MAX;
      end else if (raw_idx > {3'h0, `HQC_BAND0_MAX} && band == 6'h00) begin
         next_idx = `HQC_BAND0_MAX;
      end else if (raw_idx > {3'h0, `HQC_LVL_MAX}) begin
         next_idx = `HQC_LVL_MAX;
      end else begin
         next_idx = raw_idx[5:0];
      end
   end

   // context: band 0 index less offset, then the previous differential
   always @* begin
      if (cur == 6'h00) begin
         ctx_val = {1'b0, norm[0]} - CTX_OFS;
      end else begin
         ctx_val = {2'h0, prev_sym} - `HQC_SYM_OFS;
      end
      if (ctx_val[6]) begin
         ctx_cls = 2'h0;
      end else if (ctx_val == 7'h00) begin
         ctx_cls = 2'h1;
      end else begin
         ctx_cls = 2'h2;
      end
   end

   // cheapest method; a tie keeps the lower method code
   always @* begin
      next_method = `HQC_M_CTX;
      cost_best = cost_ctx;
      if (cost_rsz < cost_best) begin
         next_method = `HQC_M_RSZ;
         cost_best = cost_rsz;
      end
      if (cost_nrm < cost_best) begin
         next_method = `HQC_M_NRM;
         cost_best = cost_nrm;
      end
      if (cost_pack < cost_best) begin
         next_method = `HQC_M_PACK;
         cost_best = cost_pack;
      end
   end

   // fields headed for the writer: method, first index, then symbols
   always @* begin
      fifo_push = 1'b0;
      fifo_word = 12'h000;
      case (state)
         ST_MODE: begin
            fifo_push = 1'b1;
            fifo_word = {`HQC_MODE_W, 6'h00, next_method};
         end
         ST_FIRST: begin
            fifo_push = 1'b1;
            fifo_word = {`HQC_FIRST_W, 2'h0, norm[0]};
         end
         ST_SYM: begin
            fifo_push = 1'b1;
            fifo_word = {code_len, code};
         end
         default: begin
            fifo_push = 1'b0;
         end
      endcase
   end

   hqc_symbol_coder #(
      .RSZ_LEN(RSZ_LEN),
      .RSZ_CODE(RSZ_CODE),
      .CTX_LEN(CTX_LEN),
      .CTX_CODE(CTX_CODE)
   ) u_coder (
      .sym_i(cur_sym),
      .ctx_cls_i(ctx_cls),
      .method_i(method),
      .len_ctx_o(len_ctx),
      .len_rsz_o(len_rsz),
      .len_nrm_o(len_nrm),
      .code_o(code),
      .code_len_o(code_len)
   );

   // the writer can stall the coder through this buffer
   hqc_fifo #(
      .WIDTH(12),
      .DEPTH(FIFO_DEPTH),
      .AW(5)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_ready),
      .in_data_i(fifo_word),
      .out_valid_o(field_valid_o),
      .out_ready_i(field_ready_i),
      .out_data_o({field_len_o, field_data_o})
   );

   // frame sequencer
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= ST_ACC;
         sum_sq <= {SUM_W{1'b0}};
         len_cnt <= {LEN_W{1'b0}};
         quo <= {SUM_W{1'b0}};
         rem <= {(LEN_W+1){1'b0}};
         div_cnt <= 6'h00;
         band <= 6'h00;
         n_bands <= `HQC_NB_WB;
         cur <= 6'h00;
         prev_sym <= 5'h00;
         cost_ctx <= 12'h000;
         cost_rsz <= 12'h000;
         cost_nrm <= 12'h000;
         method <= `HQC_M_CTX;
         recon_valid_o <= 1'b0;
         recon_band_o <= 6'h00;
         recon_idx_o <= 6'h00;
         frame_done_o <= 1'b0;
         for (k = 0; k < `HQC_MAX_BANDS; k = k + 1) begin
            norm[k] <= 6'h00;
         end
      end else begin
         recon_valid_o <= 1'b0;
         frame_done_o <= 1'b0;
         case (state)
            ST_ACC: begin
               if (coef_take) begin
                  // band count is caught with the first coefficient of a frame
                  if (band == 6'h00 && len_cnt == {LEN_W{1'b0}}) begin
                     case (band_sel_i)
                        2'h0: n_bands <= `HQC_NB_WB;
                        2'h1: n_bands <= `HQC_NB_SWB;
                        default: n_bands <= `HQC_NB_FB;
                     endcase
                  end
                  if (coef_band_end_i) begin
                     quo <= sum_sq + {{LEN_W{1'b0}}, sq};
                     rem <= {(LEN_W+1){1'b0}};
                     div_cnt <= 6'h00;
                     state <= ST_DIV;
                  end else begin
                     sum_sq <= sum_sq + {{LEN_W{1'b0}}, sq};
                  end
                  len_cnt <= len_cnt + 1'b1;
               end
            end
            ST_DIV: begin
               // restoring divide by band length, one quotient bit a cycle
               if (div_cnt == SUM_W[5:0]) begin
                  norm[band] <= next_idx;
                  sum_sq <= {SUM_W{1'b0}};
                  len_cnt <= {LEN_W{1'b0}};
                  if (band == n_bands - 6'h01) begin
                     band <= 6'h00;
                     cur <= n_bands - 6'h02;
                     state <= ST_P1;
                  end else begin
                     band <= band + 6'h01;
                     state <= ST_ACC;
                  end
               end else begin
                  rem <= rem_ge ? rem_sh - {1'b0, len_cnt} : rem_sh;
                  quo <= {quo[SUM_W-2:0], rem_ge};
                  div_cnt <= div_cnt + 6'h01;
               end
            end
            ST_P1: begin
               // downward pass, lower band pulled up to the upper index
               if (norm[cur] > norm[cur_up] + `HQC_DIFF_NEG) begin
                  norm[cur] <= norm[cur_up];
               end
               if (cur == 6'h00) begin
                  cost_ctx <= 12'h000;
                  cost_rsz <= 12'h000;
                  cost_nrm <= 12'h000;
                  state <= ST_P2;
               end else begin
                  cur <= cur - 6'h01;
               end
            end
            ST_P2: begin
               // upward pass; the capped symbol is costed in the same step
               if (!up_diff[6] && up_diff > `HQC_DIFF_POS) begin
                  norm[cur_up] <= norm[cur] + `HQC_DIFF_POS_IDX;
               end
               cost_ctx <= cost_ctx + {8'h00, len_ctx};
               cost_rsz <= cost_rsz + {8'h00, len_rsz};
               cost_nrm <= cost_nrm + {8'h00, len_nrm};
               prev_sym <= cur_sym;
               if (cur == n_bands - 6'h02) begin
                  state <= ST_MODE;
               end else begin
                  cur <= cur_up;
               end
            end
            ST_MODE: begin
               if (fifo_ready) begin
                  method <= next_method;
                  state <= ST_FIRST;
               end
            end
            ST_FIRST: begin
               if (fifo_ready) begin
                  cur <= 6'h00;
                  prev_sym <= 5'h00;
                  state <= ST_SYM;
               end
            end
            ST_SYM: begin
               // symbols recomputed from the settled indices
               if (fifo_ready) begin
                  prev_sym <= cur_sym;
                  if (cur == n_bands - 6'h02) begin
                     cur <= 6'h00;
                     state <= ST_RECON;
                  end else begin
                     cur <= cur_up;
                  end
               end
            end
            ST_RECON: begin
               // indices after adjustment, exactly what the decoder rebuilds
               recon_valid_o <= 1'b1;
               recon_band_o <= cur;
               recon_idx_o <= norm[cur];
               if (cur == n_bands - 6'h01) begin
                  state <= ST_DONE;
               end else begin
                  cur <= cur_up;
               end
            end
            ST_DONE: begin
               frame_done_o <= 1'b1;
               cur <= 6'h00;
               state <= ST_ACC;
            end
            default: begin
               state <= ST_ACC;
            end
         endcase
      end
   end
endmodule

/* common/hqc_defs.vh */
/*
 * Constants for the band norm quantiser and envelope coder: quantiser
 * bias and limits, differential limits, field widths, method codes,
 * band counts and default tables for the parameterised Huffman codes.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef HQC_DEFS_VH
`define HQC_DEFS_VH

// quantiser
`define HQC_IDX_BIAS 34
`define HQC_LVL_MAX 6'h27
`define HQC_BAND0_MAX 6'h1F
`define HQC_SQRT2_Q16 16'hB505

// differential limits and symbol offset
`define HQC_DIFF_NEG 6'h0F
`define HQC_DIFF_POS 7'h10
`define HQC_DIFF_POS_IDX 6'h10
`define HQC_SYM_OFS 7'h0F

// field widths
`define HQC_FIRST_W 4'h5
`define HQC_MODE_W 4'h2
`define HQC_PACK_W 4'h5

// method codes
`define HQC_M_CTX 2'h0
`define HQC_M_RSZ 2'h1
`define HQC_M_NRM 2'h2
`define HQC_M_PACK 2'h3

// band counts per bandwidth select
`define HQC_NB_WB 6'h1A
`define HQC_NB_SWB 6'h27
`define HQC_NB_FB 6'h2C
`define HQC_MAX_BANDS 44

// default tables: every symbol 5 bits, code equal to the symbol
`define HQC_DEF_CTX_OFS 7'h0C
`define HQC_DEF_LEN {32{4'h5}}
`define HQC_DEF_CODE 256'h1F1E1D1C1B1A191817161514131211100F0E0D0C0B0A09080706050403020100

`endif

/* core/hqc_fifo.v */
/*
 * Synchronous FIFO in flip-flops with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module hqc_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // full and empty come straight from the occupancy count
   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // pointers wrap at depth so non-power-of-two depths also work
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* core/hqc_symbol_coder.v */
/*
 * Code lookup for one differential symbol: code lengths under the three
 * Huffman methods at once, plus code word and length for a chosen method.
 * Assumes the symbol is already offset into 0..31.
 */
`timescale 1ns/100ps
`include "hqc_defs.vh"
module hqc_symbol_coder #(
   parameter [127:0] RSZ_LEN = `HQC_DEF_LEN,
   parameter [255:0] RSZ_CODE = `HQC_DEF_CODE,
   parameter [383:0] CTX_LEN = {3{`HQC_DEF_LEN}},
   parameter [767:0] CTX_CODE = {3{`HQC_DEF_CODE}}
) (
   input wire [4:0] sym_i,
   input wire [1:0] ctx_cls_i,
   input wire [1:0] method_i,
   output wire [3:0] len_ctx_o,
   output wire [3:0] len_rsz_o,
   output wire [3:0] len_nrm_o,
   output reg [7:0] code_o,
   output reg [3:0] code_len_o
);
   reg [3:0] nrm_len;
   reg [7:0] nrm_code;

   // fixed normal table, right-aligned code words of 3 to 7 bits
   always @* begin
      nrm_len = 4'h7;
      nrm_code = 8'h00;
      if (sym_i < 5'h08) begin
         nrm_len = 4'h7;
         nrm_code = {1'b0, sym_i[1:0], 4'hD, sym_i[2]};
      end else if (sym_i < 5'h0C) begin
         nrm_len = 4'h6;
         nrm_code = {2'h0, sym_i[1:0], 4'hC};
      end else if (sym_i < 5'h0E) begin
         nrm_len = 4'h4;
         nrm_code = {4'h0, sym_i[1:0], 2'h2};
      end else if (sym_i < 5'h10) begin
         nrm_len = 4'h3;
         nrm_code = {5'h00, 1'b1, sym_i[0], 1'b0};
      end else if (sym_i < 5'h12) begin
         nrm_len = 4'h3;
         nrm_code = {5'h00, 1'b0, sym_i[0], 1'b0};
      end else if (sym_i < 5'h14) begin
         nrm_len = 4'h4;
         nrm_code = {4'h0, 1'b1, sym_i[0], 2'h2};
      end else if (sym_i < 5'h18) begin
         nrm_len = 4'h6;
         nrm_code = {2'h0, sym_i[1:0], 4'hE};
      end else if (sym_i < 5'h1C) begin
         nrm_len = 4'h7;
         nrm_code = {1'b0, sym_i[1:0], 5'h1E};
      end else begin
         nrm_len = 4'h7;
         nrm_code = {1'b0, sym_i[1:0], 5'h1F};
      end
   end

   assign len_nrm_o = nrm_len;
   assign len_rsz_o = RSZ_LEN[sym_i*4 +: 4];
   assign len_ctx_o = CTX_LEN[(ctx_cls_i*32 + sym_i)*4 +: 4];

   // word for the method the frame settled on
   always @* begin
      case (method_i)
         `HQC_M_CTX: begin
            code_o = CTX_CODE[(ctx_cls_i*32 + sym_i)*8 +: 8];
            code_len_o = len_ctx_o;
         end
         `HQC_M_RSZ: begin
            code_o = RSZ_CODE[sym_i*8 +: 8];
            code_len_o = len_rsz_o;
         end
         `HQC_M_NRM: begin
            code_o = nrm_code;
            code_len_o = nrm_len;
         end
         default: begin
            code_o = {3'h0, sym_i};
            code_len_o = `HQC_PACK_W;
         end
      endcase
   end
endmodule

/* verif/hqc_band_norm_coder_properties.sv */
/* port assertions for the band norm coder.
   assumes binding onto the coder top with its coefficient width. */
`timescale 1ns/100ps
module hqc_coder_props #(
   parameter COEF_W = 16
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [1:0] band_sel_i,
   input wire coef_valid_i,
   input wire [COEF_W-1:0] coef_i,
   input wire coef_band_end_i,
   input wire coef_ready_o,
   input wire field_valid_o,
   input wire field_ready_i,
   input wire [7:0] field_data_o,
   input wire [3:0] field_len_o,
   input wire recon_valid_o,
   input wire [5:0] recon_band_o,
   input wire [5:0] recon_idx_o,
   input wire frame_done_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   reg [5:0] prev_idx;
   wire signed [6:0] step = $signed({1'b0, recon_idx_o}) - $signed({1'b0, prev_idx});
   // previous index, for the neighbour step limit
   always @(posedge mclk_i) begin
      prev_idx <= recon_idx_o;
   end
   idx_span_a: assert property (recon_valid_o |-> recon_idx_o <= 6'h27)
      else $error("index above top level");
   first_span_a: assert property (recon_valid_o && recon_band_o == 6'h00 |-> recon_idx_o <= 6'h1F)
      else $error("lowest band index above 31");
   band_walk_a: assert property (recon_valid_o && $past(recon_valid_o)
      |-> recon_band_o == $past(recon_band_o) + 6'h01)
      else $error("recon band order broken");
   recon_start_a: assert property ($rose(recon_valid_o) |-> recon_band_o == 6'h00)
      else $error("recon burst not from band 0");
   step_limit_a: assert property (recon_valid_o && $past(recon_valid_o)
      |-> step >= -7'sd15 && step <= 7'sd16)
      else $error("neighbour step out of range");
   done_after_a: assert property ($rose(frame_done_o) |-> $past(recon_valid_o) && !recon_valid_o)
      else $error("frame done misplaced");
   band_stall_a: assert property (coef_valid_i && coef_ready_o && coef_band_end_i
      |=> !coef_ready_o [*8])
      else $error("ready back too soon after band end");
   field_hold_a: assert property (field_valid_o && !field_ready_i
      |=> field_valid_o && $stable(field_data_o) && $stable(field_len_o))
      else $error("field changed while stalled");
   field_len_a: assert property (field_valid_o |-> field_len_o >= 4'h2 && field_len_o <= 4'h8)
      else $error("field length out of range");
endmodule
bind hqc_band_norm_coder hqc_coder_props #(.COEF_W(COEF_W)) u_props (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .band_sel_i(band_sel_i), .coef_valid_i(coef_valid_i), .coef_i(coef_i),
   .coef_band_end_i(coef_band_end_i), .coef_ready_o(coef_ready_o),
   .field_valid_o(field_valid_o), .field_ready_i(field_ready_i),
   .field_data_o(field_data_o), .field_len_o(field_len_o), .recon_valid_o(recon_valid_o),
   .recon_band_o(recon_band_o), .recon_idx_o(recon_idx_o), .frame_done_o(frame_done_o));

/* verif/hqc_field_sink.sv */
/* bitstream writer model: takes coder fields, stalling at random when asked.
   assumes one clock and an active-low reset from the bench. */
`timescale 1ns/100ps
module hqc_field_sink (
   input wire mclk_i,
   input wire rst_n_i,
   input wire stall_i,
   input wire field_valid_i,
   input wire [7:0] field_data_i,
   input wire [3:0] field_len_i,
   output reg field_ready_o = 1'b0
);
   logic [11:0] got[$];
   // capture on handshake; stalls let the coder fifo fill up
   always @(posedge mclk_i) begin
      if (rst_n_i && field_valid_i && field_ready_o) begin
         got.push_back({field_len_i, field_data_i});
      end
      field_ready_o <= !stall_i || ($urandom % 3 != 0);
   end
endmodule

/* verif/hqc_band_norm_coder_tb.sv */
/* self-checking bench for the band norm coder: random and corner frames.
   assumes the coder with default tables and the field sink model. */
`timescale 1ns/100ps
module hqc_band_norm_coder_tb;
   logic mclk_i, rst_n_i, coef_valid_i, coef_band_end_i, stall;
   logic [1:0] band_sel_i;
   logic [15:0] coef_i;
   wire coef_ready_o, field_valid_o, field_ready_i, recon_valid_o, frame_done_o;
   wire [7:0] field_data_o;
   wire [3:0] field_len_o;
   wire [5:0] recon_band_o, recon_idx_o;
   int n_errors = 0, compares = 0;
   int kd[44], kk[44], ln[44];
   hqc_band_norm_coder u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .band_sel_i(band_sel_i),
      .coef_valid_i(coef_valid_i), .coef_i(coef_i), .coef_band_end_i(coef_band_end_i),
      .coef_ready_o(coef_ready_o), .field_valid_o(field_valid_o),
      .field_ready_i(field_ready_i), .field_data_o(field_data_o), .field_len_o(field_len_o),
      .recon_valid_o(recon_valid_o), .recon_band_o(recon_band_o),
      .recon_idx_o(recon_idx_o), .frame_done_o(frame_done_o));
   hqc_field_sink u_sink (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .stall_i(stall),
      .field_valid_i(field_valid_o), .field_data_i(field_data_o),
      .field_len_i(field_len_o), .field_ready_o(field_ready_i));
   // 20 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic wrap_up;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk_idx(logic [5:0] g, logic [5:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t index got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_fld(logic [11:0] g, logic [11:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t field got %h exp %h", $time, g, e);
      end
   endtask
   // kind 0 silent, 1 all +-2^k (40-2k), 2 one of two (41-2k), 3 three of four (rounds up)
   function automatic logic [5:0] raw_idx(int b, int kind, int k);
      int v, top;
      top = (b == 0) ? 31 : 39;
      v = (kind == 0) ? 99 : 40 - 2 * k + int'(kind == 2);
      if (v > top) v = top;
      return v[5:0];
   endfunction
   // fixed prefix code as {len, right-aligned code}
   function automatic logic [11:0] nrm(int s);
      int x;
      x = (s - 12) & 3;
      if (s >= 14 && s <= 17) return {4'h3, 8'(x << 1)};
      if (s >= 12 && s <= 19) return {4'h4, 8'(x << 2 | 2)};
      if (s >= 8 && s <= 23) return {4'h6, 8'((s & 3) << 4 | (s < 20 ? 12 : 14))};
      return {4'h7, 8'((s & 3) << 5 | 26 + (s >> 2 & 1) + (s >= 24 ? 4 : 0))};
   endfunction
   task automatic put(logic [15:0] c, logic e);
      logic ok;
      int t;
      coef_valid_i <= 1'b1;
      coef_i <= c;
      coef_band_end_i <= e;
      t = 0;
      do begin
         @(negedge mclk_i);
         ok = coef_ready_o;
         @(posedge mclk_i);
         t++;
      end while (ok !== 1'b1 && t < 200);
      if (t >= 200) begin
         n_errors++;
         $display("[FAIL] %0t coefficient never taken", $time);
         wrap_up;
      end
   endtask
   task automatic run_frame(int bs);
      int n, t, s, cost, bi;
      logic [5:0] ix[44];
      logic [1:0] m;
      logic [11:0] f;
      logic [15:0] v;
      @(posedge mclk_i);
      n = (bs == 0) ? 26 : (bs == 1) ? 39 : 44;
      band_sel_i <= bs[1:0];
      for (int b = 0; b < n; b++) ix[b] = raw_idx(b, kd[b], kk[b]);
      for (int b = n - 2; b >= 0; b--) if (ix[b] > ix[b + 1] + 15) ix[b] = ix[b + 1];
      for (int b = 0; b < n - 1; b++) if (ix[b + 1] > ix[b] + 16) ix[b + 1] = ix[b] + 16;
      cost = 0;
      for (int b = 0; b < n - 1; b++) begin
         f = nrm(int'(ix[b + 1]) - int'(ix[b]) + 15);
         cost += f[11:8];
      end
      m = (cost < 5 * (n - 1)) ? 2'h2 : 2'h0;
      for (int b = 0; b < n; b++) begin
         for (int c = 0; c < ln[b]; c++) begin
            v = (kd[b] == 0 || c > 0 && kd[b] == 2 || c == 3 && kd[b] == 3) ? 16'h0000
               : 16'(1 << kk[b]);
            if ($urandom % 2) v = -v;
            put(v, c == ln[b] - 1);
         end
      end
      coef_valid_i <= 1'b0;
      bi = 0;
      for (t = 0; t < 4000 && frame_done_o !== 1'b1; t++) begin
         @(negedge mclk_i);
         if (recon_valid_o === 1'b1) begin
            chk_idx(recon_band_o, bi[5:0]);
            chk_idx(recon_idx_o, ix[bi]);
            bi++;
         end
      end
      if (frame_done_o !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t frame never finished", $time);
         wrap_up;
      end
      chk_idx(6'(bi), 6'(n));
      for (t = 0; t < 200 && field_valid_o !== 1'b0; t++) @(negedge mclk_i);
      if (field_valid_o !== 1'b0) begin
         n_errors++;
         $display("[FAIL] %0t fields never drained", $time);
         wrap_up;
      end
      for (int i = 0; i < u_sink.got.size(); i++) begin
         f = u_sink.got[i];
         f[7:0] = f[7:0] & ((8'h01 << f[11:8]) - 8'h01);
         s = (i > 1) ? int'(ix[i - 1]) - int'(ix[i - 2]) + 15 : 0;
         if (i == 0) chk_fld(f, {4'h2, 6'h00, m});
         else if (i == 1) chk_fld(f, {4'h5, 3'h0, ix[0][4:0]});
         else chk_fld(f, (m == 2'h2) ? nrm(s) : {4'h5, 8'(s)});
      end
      chk_fld(12'(u_sink.got.size()), 12'(n + 1));
      u_sink.got.delete();
   endtask
   // reset, two hand-written frames, then random frames on every band select
   initial begin
      void'($urandom(53535));
      rst_n_i = 1'b0;
      coef_valid_i = 1'b0;
      coef_band_end_i = 1'b0;
      coef_i = 16'h0000;
      band_sel_i = 2'h0;
      stall = 1'b0;
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // silent first band, loud middle, silent top: both passes fire
      for (int b = 0; b < 44; b++) begin
         kd[b] = (b > 0 && b < 22) ? 1 : 0;
         kk[b] = 14;
         ln[b] = 1;
      end
      run_frame(2);
      // flat spectrum: prefix code is cheapest
      for (int b = 0; b < 44; b++) begin
         kd[b] = 1;
         kk[b] = 5;
         ln[b] = 3;
      end
      stall <= 1'b1;
      run_frame(0);
      for (int r = 0; r < 4; r++) begin
         for (int b = 0; b < 44; b++) begin
            kd[b] = $urandom % 4;
            kk[b] = (r == 3) ? 0 : 1 + $urandom % 14;
            ln[b] = (kd[b] == 2) ? 2 : (kd[b] == 3) ? 4 : 1 + $urandom % 4;
         end
         stall <= r[0];
         run_frame(r);
      end
      wrap_up;
   end
endmodule
